// file: src/adcc_pkg.sv
// Constants for the converter control block: register map, field layout,
// reset values and conversion timing.
// Assumes a 32-bit Avalon-MM bus with word-aligned byte addresses.
package adcc_pkg;
  localparam int unsigned AW = 5;
  // Register byte offsets
  localparam logic [AW-1:0] OFS_CTRL   = 5'h00;
  localparam logic [AW-1:0] OFS_RESULT = 5'h04;
  localparam logic [AW-1:0] OFS_P6DIR  = 5'h08;
  localparam logic [AW-1:0] OFS_IRQ_ST = 5'h0C;
  localparam logic [AW-1:0] OFS_IRQ_EN = 5'h10;
  localparam logic [AW-1:0] OFS_IRQ_CL = 5'h14;
  // Control register fields
  localparam int unsigned B_DONE  = 7;
  localparam int unsigned B_START = 6;
  localparam int unsigned B_AIDIS = 4;
  localparam int unsigned CH_W    = 4;
  localparam int unsigned MUX_W   = 3;
  // Interrupt status bits
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned I_DONE    = 0;
  localparam int unsigned I_ABORT   = 1;
  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic        RST_AIDIS = 1'b1;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
  // Timing: machine cycles per conversion, sampling window and bit slot
  localparam int unsigned CONV_MCYC   = 46;
  localparam int unsigned SAMPLE_MCYC = 4;
  localparam int unsigned SLOT_MCYC   = 5;
  localparam int unsigned FC_PER_MCYC = 4;
  localparam int unsigned CONV_CLKS   = CONV_MCYC * FC_PER_MCYC;
endpackage : adcc_pkg

// file: src/adcc_sar.sv
// Successive-approximation sequencer, paced by machine-cycle ticks.
// Assumes the analog side compares the held input with o_dac_code.
`timescale 1ns/1ps
module adcc_sar
  import adcc_pkg::*;
#(
  parameter int unsigned DIV = FC_PER_MCYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  wire logic       i_cmp_hi,
  output logic            o_busy,
  output logic            o_sample,
  output logic            o_done,
  output logic [7:0]      o_code
);
  logic [7:0] div_ff, mc_ff, trial_ff, bit_ff;
  logic [2:0] ph_ff;
  wire        tick     = o_busy && (div_ff == 8'(DIV - 1));
  wire        samp_end = tick && (mc_ff == 8'(SAMPLE_MCYC - 1));
  wire        bit_end  = tick && (bit_ff != RST_BYTE)
                         && (ph_ff == 3'(SLOT_MCYC - 1));
  wire        last     = tick && (mc_ff == 8'(CONV_MCYC - 1)); // see [RULE4]

  // Divider and machine-cycle counters restart on every start so timing is exact; the slot counter restarts at sampling end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      div_ff <= RST_BYTE;
      mc_ff  <= RST_BYTE;
      ph_ff  <= 3'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= last && !i_abort;
      if (i_start) begin
        o_busy <= 1'b1;
        div_ff <= RST_BYTE;
        mc_ff  <= RST_BYTE;
      end else if (i_abort || last) begin
        o_busy <= 1'b0;
      end else if (o_busy) begin
        div_ff <= tick ? RST_BYTE : div_ff + 8'h01;
        mc_ff  <= tick ? mc_ff + 8'h01 : mc_ff;
        if (samp_end || bit_end) ph_ff <= 3'h0;
        else if (tick) ph_ff <= ph_ff + 3'h1;
      end
    end
  end

  // Trial code: keep a bit only while the input sits at or above the DAC level
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      trial_ff <= RST_BYTE;
      bit_ff   <= RST_BYTE;
    end else if (i_start) begin
      trial_ff <= RST_BYTE;
      bit_ff   <= RST_BYTE;
    end else if (samp_end) begin
      trial_ff <= 8'h80;
      bit_ff   <= 8'h80;
    end else if (bit_end) begin
      trial_ff <= (i_cmp_hi ? trial_ff : trial_ff & ~bit_ff) | (bit_ff >> 1);
      bit_ff   <= bit_ff >> 1;
    end
  end

  assign o_sample = o_busy && (mc_ff < 8'(SAMPLE_MCYC));
  assign o_code   = trial_ff;
endmodule : adcc_sar

// file: src/adcc_top.sv
// Converter control block: register file on Avalon-MM, start/done/abort
// sequencing, result capture, interrupt status and analog-side controls.
// Assumes an external mux, sample-and-hold, DAC ladder and comparator.
//
// Function
// [RULE1] Software sets the port-6 direction bit of a pin before analog use.
// [RULE2] Analog disable bit 4 cleared, then bits 3-0 pick one of eight inputs.
// [RULE3] Writing 1 to start bit 6 begins converting the selected channel.
// [RULE4] A conversion completes 46 machine cycles after it starts.
// [RULE5] Done flag at bit 7 is set at the end of each conversion.
// [RULE6] Reading the result register clears the done flag automatically.
// [RULE7] Stop mode during conversion aborts it; result then undefined.
// [RULE8] Stop mode after a finished conversion keeps the result unchanged.
// [RULE9] Software avoids port output during conversion; other pins stay ports.
// [RULE10] Result register loads only at conversion end, unsigned code.
// [RULE11] Start bit reads back 0 once the conversion is accepted.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int unsigned DIV = FC_PER_MCYC
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst,
  input  wire logic [AW-1:0] i_avm_address,
  input  wire logic          i_avm_read,
  input  wire logic          i_avm_write,
  input  wire logic [31:0]   i_avm_writedata,
  input  wire logic [3:0]    i_avm_byteenable,
  input  wire logic          i_cmp_hi,
  input  wire logic          i_stop_mode,
  output logic [31:0]        o_avm_readdata,
  output logic               o_avm_waitrequest,
  output logic               o_irq,
  output logic [MUX_W-1:0]   o_mux_sel,
  output logic               o_mux_dis,
  output logic               o_sample,
  output logic [7:0]         o_dac_code,
  output logic [7:0]         o_port6_dir,
  output logic               o_busy
);
  // Register state
  logic [CH_W-1:0]  chan_ff;
  logic             aidis_ff;
  logic             start_ff;
  logic             done_ff;
  logic [7:0]       result_ff;
  logic [IRQ_W-1:0] ist_ff;
  logic [IRQ_W-1:0] ien_ff;
  logic             sar_busy;
  logic             sar_samp;
  logic             sar_done;
  logic [7:0]       sar_code;

  // Bus decode: a request is taken on the edge where waitrequest is low
  wire req      = i_avm_read || i_avm_write;
  wire acc      = req && !o_avm_waitrequest;
  wire wr_acc   = acc && i_avm_write && i_avm_byteenable[0];
  wire rd_acc   = acc && i_avm_read;
  wire sel_ctrl = (i_avm_address == OFS_CTRL);
  wire sel_res  = (i_avm_address == OFS_RESULT);
  wire sel_p6   = (i_avm_address == OFS_P6DIR);
  wire sel_ist  = (i_avm_address == OFS_IRQ_ST);
  wire sel_ien  = (i_avm_address == OFS_IRQ_EN);
  wire sel_icl  = (i_avm_address == OFS_IRQ_CL);
  wire [7:0] wb = i_avm_writedata[7:0];

  // Control side effects
  wire wr_ctrl   = wr_acc && sel_ctrl;
  wire go        = wr_ctrl && wb[B_START];                // see [RULE3]
  wire res_rd    = rd_acc && sel_res;
  wire abort     = sar_busy && i_stop_mode;               // see [RULE7]
  wire [IRQ_W-1:0] ev = {abort, sar_done};
  wire [IRQ_W-1:0] icl = (wr_acc && sel_icl) ? wb[IRQ_W-1:0] : '0;

  // Read mux: unmapped offsets read as zero
  wire [7:0] ctrl_rd = {done_ff, start_ff, 1'b0, aidis_ff, chan_ff};
  wire [7:0] rd_byte = sel_ctrl ? ctrl_rd :
                       sel_res  ? result_ff :
                       sel_p6   ? o_port6_dir :
                       sel_ist  ? 8'(ist_ff) :
                       sel_ien  ? 8'(ien_ff) : RST_BYTE;

  wire nxt_irq = |((ist_ff & ~icl | ev) & ien_ff);

  // Waitrequest drops for one cycle after a request appears
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avm_waitrequest <= 1'b1;
      o_avm_readdata    <= RD_ZERO;
    end else begin
      o_avm_waitrequest <= !(req && o_avm_waitrequest);
      o_avm_readdata    <= {24'h00_0000, rd_byte};
    end
  end

  // Channel selection, disable bit and pin direction register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      chan_ff     <= '0;
      aidis_ff    <= RST_AIDIS;
      o_port6_dir <= RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        chan_ff  <= wb[CH_W-1:0];                         // see [RULE2]
        aidis_ff <= wb[B_AIDIS];                          // see [RULE2]
      end
      if (wr_acc && sel_p6) o_port6_dir <= wb;            // see [RULE1]
    end
  end

  // Start is a one-cycle request; it reads 0 again straight away
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) start_ff <= 1'b0;
    else       start_ff <= go;                            // see [RULE11]
  end

  // Done flag: hardware set beats the read clear of the same cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst)         done_ff <= 1'b0;
    else if (sar_done) done_ff <= 1'b1;                   // see [RULE5]
    else if (res_rd)   done_ff <= 1'b0;                   // see [RULE6]
  end

  // Result loads only on completion, so stop mode afterwards keeps it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst)         result_ff <= RST_BYTE;
    else if (sar_done) result_ff <= sar_code;             // see [RULE10]
  end                                                     // see [RULE8]

  // Interrupt status: sticky, set wins over write-one clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ist_ff <= '0;
      ien_ff <= '0;
      o_irq  <= 1'b0;
    end else begin
      ist_ff <= (ist_ff & ~icl) | ev;
      if (wr_acc && sel_ien) ien_ff <= wb[IRQ_W-1:0];
      o_irq  <= nxt_irq;
    end
  end

  // Analog-side controls registered so the pins never glitch
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mux_sel  <= '0;
      o_mux_dis  <= RST_AIDIS;
      o_sample   <= 1'b0;
      o_dac_code <= RST_BYTE;
      o_busy     <= 1'b0;
    end else begin
      o_mux_sel  <= chan_ff[MUX_W-1:0];                   // see [RULE2]
      o_mux_dis  <= aidis_ff;
      o_sample   <= sar_samp;
      o_dac_code <= sar_code;
      o_busy     <= sar_busy;
    end
  end

  // Stop mode wins over a start in the same cycle
  adcc_sar #(
    .DIV      (DIV)
  ) u_sar (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_start   (start_ff && !i_stop_mode),
    .i_abort   (abort),
    .i_cmp_hi  (i_cmp_hi),
    .o_busy    (sar_busy),
    .o_sample  (sar_samp),
    .o_done    (sar_done),
    .o_code    (sar_code)
  );

  // Helper: clocks since the latest start request, whether or not stop mode blocks it
  logic [8:0] conv_cnt;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst)                   conv_cnt <= '0;
    else if (start_ff)           conv_cnt <= '0;
    else if (conv_cnt != 9'h1FF) conv_cnt <= conv_cnt + 9'h001;
  end

  sequence s_take_result;
    rd_acc && sel_res && !sar_done;
  endsequence
  sequence s_take_start;
    start_ff && !i_stop_mode;
  endsequence

  a_start_reads_zero: assert property (@(posedge i_sys_clk) // see [RULE11]
    disable iff (i_rst) go |=> start_ff ##1 !start_ff)
    else $error("start bit did not fall back to 0");

  a_start_begins: assert property (@(posedge i_sys_clk) // see [RULE3]
    disable iff (i_rst) s_take_start |=> sar_busy ##2 o_busy)
    else $error("accepted start did not begin a conversion");

  a_conv_length: assert property (@(posedge i_sys_clk) // see [RULE4]
    disable iff (i_rst) sar_done |-> conv_cnt == 9'(CONV_MCYC * DIV))
    else $error("conversion length is not 46 machine cycles");

  a_done_flag_set: assert property (@(posedge i_sys_clk) // see [RULE5]
    disable iff (i_rst) sar_done |=> done_ff ##1 o_avm_readdata[B_DONE]
      || !($past(sel_ctrl)))
    else $error("done flag not set at end of conversion");

  a_result_read_clr: assert property (@(posedge i_sys_clk) // see [RULE6]
    disable iff (i_rst) s_take_result |=> !done_ff)
    else $error("result read did not clear done flag");

  a_stop_aborts: assert property (@(posedge i_sys_clk) // see [RULE7]
    disable iff (i_rst) sar_busy && i_stop_mode |=> !sar_busy && !sar_done
      ##1 ist_ff[I_ABORT])
    else $error("stop mode did not abort the conversion");

  a_hold_result: assert property (@(posedge i_sys_clk) // see [RULE8]
    disable iff (i_rst) done_ff && i_stop_mode && !sar_busy
      |=> $stable(result_ff))
    else $error("result changed in stop mode after done");

  a_result_load: assert property (@(posedge i_sys_clk) // see [RULE10]
    disable iff (i_rst) !$stable(result_ff) |-> $past(sar_done))
    else $error("result changed outside conversion end");

  a_mux_follow: assert property (@(posedge i_sys_clk) // see [RULE2]
    disable iff (i_rst) wr_ctrl |=> ##1 o_mux_sel == $past(wb[MUX_W-1:0], 2)
      && o_mux_dis == $past(wb[B_AIDIS], 2))
    else $error("channel select not driven to the mux");
endmodule : adcc_top

// file: dv/adcc_analog_model.sv
// Analog side model: eight fixed input levels, sample-and-hold, comparator.
// Assumes the converter drives mux, sample and trial code on one clock.
`timescale 1ns/1ps
module adcc_analog_model
  import adcc_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic [MUX_W-1:0] i_mux_sel,
  input  wire logic             i_mux_dis,
  input  wire logic             i_sample,
  input  wire logic [7:0]       i_dac_code,
  output logic                  o_cmp_hi
);
  logic [7:0] held_ff;
  logic [7:0] nxt_held;
  // Level ramps with the channel so each input gives a distinct code
  assign nxt_held = 8'h15 + 8'h1D * {5'h00, i_mux_sel};
  // A disabled mux feeds no input, so the hold cap drifts to garbage
  always_ff @(posedge i_sys_clk) begin
    if (i_sample) begin
      held_ff <= i_mux_dis ? ~held_ff : nxt_held;
    end
  end
  // Comparator is high once the held level reaches the trial code
  assign o_cmp_hi = (held_ff >= i_dac_code);
endmodule : adcc_analog_model

// file: dv/testbench.sv
// Self-checking bench for the converter control block.
// Assumes the analog model on the far side; machine cycle shortened to 2.
`timescale 1ns/1ps
module testbench
  import adcc_pkg::*;
;
  localparam int unsigned DIVT  = 2;
  localparam int unsigned TCONV = CONV_MCYC * DIVT;
  logic             clk;
  logic             rst;
  logic [AW-1:0]    addr;
  logic             rd;
  logic             wr;
  logic [31:0]      wdata;
  logic [3:0]       be;
  logic             cmp_hi;
  logic             stop;
  logic [31:0]      rdata;
  logic             waitreq;
  logic             irq;
  logic [MUX_W-1:0] mux_sel;
  logic             mux_dis;
  logic             sample;
  logic [7:0]       dac;
  logic             busy;
  logic [7:0]       rv;
  int               n;
  int               err_count;
  int               tests_run;

  adcc_top #(.DIV(DIVT)) uut (
    .i_sys_clk(clk), .i_rst(rst), .i_avm_address(addr),
    .i_avm_read(rd), .i_avm_write(wr), .i_avm_writedata(wdata),
    .i_avm_byteenable(be), .i_cmp_hi(cmp_hi), .i_stop_mode(stop),
    .o_avm_readdata(rdata), .o_avm_waitrequest(waitreq), .o_irq(irq),
    .o_mux_sel(mux_sel), .o_mux_dis(mux_dis), .o_sample(sample),
    .o_dac_code(dac), .o_port6_dir(), .o_busy(busy)
  );
  adcc_analog_model model (
    .i_sys_clk(clk), .i_mux_sel(mux_sel), .i_mux_dis(mux_dis),
    .i_sample(sample), .i_dac_code(dac), .o_cmp_hi(cmp_hi)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [AW-1:0] a,
                     input logic [7:0] d, input logic [3:0] b);
    int k;
    @(posedge clk);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= {24'h000000, d};
    be    <= b;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 16);
    rv = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      err_count++;
      final_report();
    end
  endtask : bus

  task automatic wr8(input logic [AW-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr8

  task automatic rd8(input logic [AW-1:0] a);
    bus(1'b0, a, 8'h00, 4'hF);
  endtask : rd8

  // Counts edges until the interrupt line is seen high; bounded wait
  task automatic wait_irq;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 400);
    if (n >= 400) begin
      err_count++;
      final_report();
    end
  endtask : wait_irq

  task automatic t_reset_regs;
    rd8(OFS_CTRL);
    check(rv, 8'h10);
    rd8(OFS_RESULT);
    check(rv, 8'h00);
    check({7'h00, mux_dis}, 8'h01);
    wr8(5'h18, 8'hFF);
    rd8(5'h18);
    check(rv, 8'h00);
    bus(1'b1, OFS_P6DIR, 8'hFF, 4'h0);
    rd8(OFS_P6DIR);
    check(rv, 8'h00);
  endtask : t_reset_regs

  // Every channel converted, timed, read back and acknowledged
  task automatic t_convert_all;
    wr8(OFS_IRQ_EN, 8'h01);
    for (int ch = 0; ch < 8; ch++) begin
      wr8(OFS_P6DIR, 8'h01 << ch);
      wr8(OFS_CTRL, 8'h40 | 8'(ch));
      wait_irq();
      check(8'(n), 8'(TCONV + 2));
      check({5'h00, mux_sel}, 8'(ch));
      rd8(OFS_CTRL);
      check(rv, 8'h80 | 8'(ch));
      rd8(OFS_RESULT);
      check(rv, 8'h15 + 8'h1D * 8'(ch));
      rd8(OFS_CTRL);
      check(rv, 8'(ch));
      wr8(OFS_IRQ_CL, 8'h01);
      rd8(OFS_IRQ_ST);
      check({rv[7:1], irq}, 8'h00);
    end
  endtask : t_convert_all

  // Stop mid-conversion: no done flag, abort event masked then enabled
  task automatic t_stop_abort;
    wr8(OFS_CTRL, 8'h43);
    repeat (20) @(posedge clk);
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    stop <= 1'b0;
    #1;
    check({7'h00, busy}, 8'h00);
    repeat (TCONV) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    rd8(OFS_CTRL);
    check(rv, 8'h03);
    rd8(OFS_IRQ_ST);
    check(rv, 8'h02);
    wr8(OFS_IRQ_EN, 8'h02);
    wait_irq();
    check(8'(n), 8'h01);
    wr8(OFS_IRQ_CL, 8'h02);
    rd8(OFS_IRQ_ST);
    check({rv[7:1], irq}, 8'h00);
  endtask : t_stop_abort

  // Stop after completion keeps the result and the done flag
  task automatic t_stop_after;
    wr8(OFS_IRQ_EN, 8'h01);
    wr8(OFS_CTRL, 8'h45);
    wait_irq();
    @(posedge clk);
    stop <= 1'b1;
    repeat (10) @(posedge clk);
    stop <= 1'b0;
    rd8(OFS_CTRL);
    check(rv, 8'h85);
    rd8(OFS_RESULT);
    check(rv, 8'h15 + 8'h1D * 8'h05);
  endtask : t_stop_after

  // Reset for four cycles, then the scenarios in turn
  initial begin
    err_count = 0;
    tests_run = 0;
    rst   = 1'b1;
    addr  = 5'h00;
    rd    = 1'b0;
    wr    = 1'b0;
    wdata = 32'h00000000;
    be    = 4'h0;
    stop  = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_convert_all();
    t_stop_abort();
    t_stop_after();
    final_report();
  end
endmodule : testbench
